// >>> hdl/psfr_status_readback.sv
// Purpose: Read-only PLL status flags with change interrupts.
// Assumes: Flag inputs come from other clock domains; one clock clk.
// Notes:   Upper four bits of the status readback read as zero.
//          A flag already high at reset release logs a rise event.
//          Helper cells below are combinational; all state is in s_q.
// Behaviour
// - The VCO comparison flag reads 1 above its threshold, 0 below.
// - Status bit 2 reads 1 when reference input two is above threshold.
// - Status bit 1 reads 1 when reference input one is above threshold.
// - The status flags are read-only; writes never alter them.
// - The VCO comparison flag sits at bit 3 of the status register.
`timescale 1ns/1ps
module psfr_status_readback
  import psfr_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output      logic [DATA_W-1:0] reg_rdata,
  // Raw flags from the monitors
  input  wire logic              vco_above_threshold,
  input  wire logic              ref_two_above_threshold,
  input  wire logic              ref_one_above_threshold,
  input  wire logic              pll_locked,
  // Control and interrupt
  output      logic              thresh_sel,
  output      logic              irq
);

  psfr_state_t       s_q;
  psfr_state_t       s_d;
  logic [NFLAG-1:0]  raw_flags;
  logic [NFLAG-1:0]  flag_rises;
  logic [NFLAG-1:0]  flag_falls;
  logic [DATA_W-1:0] status_view;
  logic [DATA_W-1:0] new_events;
  logic [DATA_W-1:0] w1c;
  logic [DATA_W-1:0] irq_stat_nxt;
  logic [DATA_W-1:0] irq_mask_nxt;
  logic [DATA_W-1:0] ref_ctrl_nxt;
  logic [DATA_W-1:0] rd_word;
  logic              wr_ref_ctrl;
  logic              wr_irq_mask;
  logic              wr_irq_stat;
  logic              rd_status;
  logic              rd_ref_ctrl;
  logic              rd_irq_stat;
  logic              rd_irq_mask;

  // Flag packing fixes each flag's bit position
  always_comb begin
    raw_flags              = FLAGS_RST;
    raw_flags[VCO_BIT]     = vco_above_threshold;
    raw_flags[REF_TWO_BIT] = ref_two_above_threshold;
    raw_flags[REF_ONE_BIT] = ref_one_above_threshold;
    raw_flags[LOCK_BIT]    = pll_locked;
  end

  // Only the second stage is visible; stage one may be metastable
  assign status_view = {4'h0, s_q.sync_b};

  // Address decode, one strobe per register and direction
  psfr_addr_decode u_decode (
    .reg_addr    (reg_addr),
    .reg_wr      (reg_wr),
    .reg_rd      (reg_rd),
    .wr_ref_ctrl (wr_ref_ctrl),
    .wr_irq_mask (wr_irq_mask),
    .wr_irq_stat (wr_irq_stat),
    .rd_status   (rd_status),
    .rd_ref_ctrl (rd_ref_ctrl),
    .rd_irq_stat (rd_irq_stat),
    .rd_irq_mask (rd_irq_mask)
  );

  // One edge cell per synchronised flag
  for (genvar gi = 0; gi < NFLAG; gi++) begin : g_edge
    psfr_flag_edge u_edge (
      .prev_lvl (s_q.prev[gi]),
      .now_lvl  (s_q.sync_b[gi]),
      .rise     (flag_rises[gi]),
      .fall     (flag_falls[gi])
    );
  end

  // Rising edges in the low nibble, falling edges in the high nibble
  assign new_events = {flag_falls, flag_rises};

  // Write-one-to-clear mask for the interrupt status
  assign w1c = wr_irq_stat ? reg_wdata : ZERO_BYTE;

  // One sticky cell per interrupt status bit
  for (genvar gb = 0; gb < DATA_W; gb++) begin : g_sticky
    psfr_sticky_bit u_bit (
      .cur_bit (s_q.irq_stat[gb]),
      .clr_bit (w1c[gb]),
      .set_bit (new_events[gb]),
      .nxt_bit (irq_stat_nxt[gb])
    );
  end

  // Writable bytes; the status register has no such cell
  psfr_rw_byte u_ref_ctrl (
    .cur_val (s_q.ref_ctrl),
    .wr_en   (wr_ref_ctrl),
    .wr_val  (reg_wdata),
    .nxt_val (ref_ctrl_nxt)
  );
  psfr_rw_byte u_irq_mask (
    .cur_val (s_q.irq_mask),
    .wr_en   (wr_irq_mask),
    .wr_val  (reg_wdata),
    .nxt_val (irq_mask_nxt)
  );

  // Read word, zero for idle cycles and unmapped addresses
  psfr_read_mux u_rmux (
    .rd_status   (rd_status),
    .rd_ref_ctrl (rd_ref_ctrl),
    .rd_irq_stat (rd_irq_stat),
    .rd_irq_mask (rd_irq_mask),
    .status_word (status_view),
    .ref_ctrl    (s_q.ref_ctrl),
    .irq_stat    (s_q.irq_stat),
    .irq_mask    (s_q.irq_mask),
    .rd_word     (rd_word)
  );

  // Next state of every register; read data stands one cycle only
  always_comb begin
    s_d          = s_q;
    s_d.sync_a   = raw_flags;
    s_d.sync_b   = s_q.sync_a;
    s_d.prev     = s_q.sync_b;
    s_d.irq_stat = irq_stat_nxt;
    s_d.irq_mask = irq_mask_nxt;
    s_d.ref_ctrl = ref_ctrl_nxt;
    s_d.rdata    = rd_word;
  end

  // State register; reset is synchronous like the register port inputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q.sync_a   <= FLAGS_RST;
      s_q.sync_b   <= FLAGS_RST;
      s_q.prev     <= FLAGS_RST;
      s_q.irq_stat <= ZERO_BYTE;
      s_q.irq_mask <= IRQ_MASK_RST;
      s_q.ref_ctrl <= REF_CTRL_RST;
      s_q.rdata    <= ZERO_BYTE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs; read data straight from its flip-flops
  assign reg_rdata  = s_q.rdata;
  assign thresh_sel = s_q.ref_ctrl[THRESH_SEL_BIT];

  // Level interrupt from status and mask
  psfr_irq_reduce u_irq (
    .stat_bits (s_q.irq_stat),
    .mask_bits (s_q.irq_mask),
    .irq_lvl   (irq)
  );

endmodule // psfr_status_readback

// Address decode: one strobe per register and direction;
// the status offset gets a read strobe and never a write strobe
module psfr_addr_decode
  import psfr_pkg::*;
(
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  // Write strobes
  output      logic              wr_ref_ctrl,
  output      logic              wr_irq_mask,
  output      logic              wr_irq_stat,
  // Read strobes
  output      logic              rd_status,
  output      logic              rd_ref_ctrl,
  output      logic              rd_irq_stat,
  output      logic              rd_irq_mask
);

  // Writes; a write to the status offset matches nothing
  assign wr_ref_ctrl = reg_wr && (reg_addr == REF_CTRL_OFS);
  assign wr_irq_mask = reg_wr && (reg_addr == IRQ_MASK_OFS);
  assign wr_irq_stat = reg_wr && (reg_addr == IRQ_STATUS_OFS);

  // Reads; unmapped addresses raise no strobe and read as zero
  assign rd_status   = reg_rd && (reg_addr == PLL_STATUS_OFS);
  assign rd_ref_ctrl = reg_rd && (reg_addr == REF_CTRL_OFS);
  assign rd_irq_stat = reg_rd && (reg_addr == IRQ_STATUS_OFS);
  assign rd_irq_mask = reg_rd && (reg_addr == IRQ_MASK_OFS);

endmodule // psfr_addr_decode

// Edge cell: splits one level change into a rise and a fall;
// both levels come from flip-flops, so the pulses are glitch free
module psfr_flag_edge (
  // Levels one cycle apart
  input  wire logic prev_lvl,
  input  wire logic now_lvl,
  // Edge pulses
  output      logic rise,
  output      logic fall
);

  // Each pulse lasts the single cycle in which the levels differ
  assign rise = now_lvl & ~prev_lvl;
  assign fall = prev_lvl & ~now_lvl;

endmodule // psfr_flag_edge

// Sticky cell: one interrupt status bit, cleared by writing a one
module psfr_sticky_bit (
  // Current value and requests
  input  wire logic cur_bit,
  input  wire logic clr_bit,
  input  wire logic set_bit,
  // Next value
  output      logic nxt_bit
);

  // Set beats clear in one cycle, so an event is never lost
  assign nxt_bit = set_bit | (cur_bit & ~clr_bit);

endmodule // psfr_sticky_bit

// Read-write byte: loads on its own write strobe, else holds
module psfr_rw_byte
  import psfr_pkg::*;
(
  // Current value
  input  wire logic [DATA_W-1:0] cur_val,
  // Write side
  input  wire logic              wr_en,
  input  wire logic [DATA_W-1:0] wr_val,
  // Next value
  output      logic [DATA_W-1:0] nxt_val
);

  // Hold unless this byte's strobe is high
  assign nxt_val = wr_en ? wr_val : cur_val;

endmodule // psfr_rw_byte

// Interrupt level: high while any unmasked status bit is set
module psfr_irq_reduce
  import psfr_pkg::*;
(
  // Status and mask of the same layout
  input  wire logic [DATA_W-1:0] stat_bits,
  input  wire logic [DATA_W-1:0] mask_bits,
  // Level out
  output      logic              irq_lvl
);

  // No flip-flop here: both inputs are registers already
  assign irq_lvl = |(stat_bits & mask_bits);

endmodule // psfr_irq_reduce

// Read multiplexer: picks the addressed register for the read flop;
// selects are one-hot from the decoder, or all low
module psfr_read_mux
  import psfr_pkg::*;
(
  // Read selects
  input  wire logic              rd_status,
  input  wire logic              rd_ref_ctrl,
  input  wire logic              rd_irq_stat,
  input  wire logic              rd_irq_mask,
  // Register words
  input  wire logic [DATA_W-1:0] status_word,
  input  wire logic [DATA_W-1:0] ref_ctrl,
  input  wire logic [DATA_W-1:0] irq_stat,
  input  wire logic [DATA_W-1:0] irq_mask,
  // Selected word
  output      logic [DATA_W-1:0] rd_word
);

  logic [3:0] sel;

  // Select vector, one bit per readable register
  assign sel = {rd_irq_mask, rd_irq_stat, rd_ref_ctrl, rd_status};

  // Idle cycles, unmapped reads and illegal mixes fall to zero
  always_comb begin
    rd_word = ZERO_BYTE;
    unique case (sel)
      4'h1:    rd_word = status_word;
      4'h2:    rd_word = ref_ctrl;
      4'h4:    rd_word = irq_stat;
      4'h8:    rd_word = irq_mask;
      default: rd_word = ZERO_BYTE;
    endcase
  end

endmodule // psfr_read_mux

// >>> hdl/psfr_pkg.sv
// Purpose: Constants and types for the PLL status flag readback block.
// Assumes: 8-bit register data, 10-bit register address.
// Notes:   Flag order in every vector is {vco, ref two, ref one, lock}.
package psfr_pkg;

  // Register port widths and flag count
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int NFLAG  = 4;

  // Register offsets
  localparam logic [ADDR_W-1:0] REF_CTRL_OFS   = 10'h01A;
  localparam logic [ADDR_W-1:0] PLL_STATUS_OFS = 10'h01F;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 10'h0F0;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS   = 10'h0F1;

  // Field positions in the status readback register
  localparam int LOCK_BIT     = 0;
  localparam int REF_ONE_BIT  = 1;
  localparam int REF_TWO_BIT  = 2;
  localparam int VCO_BIT      = 3;
  // Threshold select inside the reference control register
  localparam int THRESH_SEL_BIT = 6;

  // Reset values
  localparam logic [DATA_W-1:0] REF_CTRL_RST = 8'h00;
  localparam logic [DATA_W-1:0] IRQ_MASK_RST = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE    = 8'h00;
  localparam logic [NFLAG-1:0]  FLAGS_RST    = 4'h0;

  // Whole state of the block
  typedef struct packed {
    logic [NFLAG-1:0]  sync_a;   // First synchroniser stage
    logic [NFLAG-1:0]  sync_b;   // Second synchroniser stage
    logic [NFLAG-1:0]  prev;     // Previous synchronised flags
    logic [DATA_W-1:0] irq_stat; // {falls[7:4], rises[3:0]}
    logic [DATA_W-1:0] irq_mask;
    logic [DATA_W-1:0] ref_ctrl;
    logic [DATA_W-1:0] rdata;
  } psfr_state_t;

endpackage : psfr_pkg

// >>> bench/psfr_checker.sv
// Purpose: Port timing checks for the status readback block.
// Assumes: One clock; flags held low while reset is high.
// Notes:   A status read returns the raw flags of three edges back.
`timescale 1ns/1ps
module psfr_checker
  import psfr_pkg::*;
(
  // Register port
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       thresh_sel,
  // Raw flags
  input wire logic       vco_above_threshold,
  input wire logic       ref_two_above_threshold,
  input wire logic       ref_one_above_threshold,
  input wire logic       pll_locked
);
  // Skip reads whose sync path still holds reset values
  logic [1:0] rst_q;
  wire st_rd = reg_rd && reg_addr == PLL_STATUS_OFS && rst_q == 2'h0;
  always_ff @(posedge clk) rst_q <= {rst_q[0], sys_rst};
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Two sync stages plus the read register
  a_vco_bit: assert property (st_rd |=>
    reg_rdata[3] == $past(vco_above_threshold, 3)) else $error("vco bit");
  a_ref_two: assert property (st_rd |=>
    reg_rdata[2] == $past(ref_two_above_threshold, 3)) else $error("ref two");
  a_ref_one: assert property (st_rd |=>
    reg_rdata[1] == $past(ref_one_above_threshold, 3)) else $error("ref one");
  a_lock_bit: assert property (st_rd |=>
    reg_rdata[0] == $past(pll_locked, 3)) else $error("lock bit");
  a_upper_zero: assert property (st_rd |=> reg_rdata[7:4] == 4'h0)
    else $error("upper bits");
  a_no_leak: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("rdata leak");
  a_thresh_sel: assert property (reg_wr && reg_addr == REF_CTRL_OFS |=>
    thresh_sel == $past(reg_wdata[6])) else $error("thresh sel");
endmodule // psfr_checker
bind psfr_status_readback psfr_checker chk_i (.clk, .sys_rst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .thresh_sel, .pll_locked,
  .vco_above_threshold, .ref_two_above_threshold, .ref_one_above_threshold);

// >>> bench/psfr_status_readback_bench.sv
// Purpose: Register test of the status readback block.
// Assumes: Flags change only between reads.
// Notes:   Expected reads follow the flag pattern driven.
`timescale 1ns/1ps
module psfr_status_readback_bench
  import psfr_pkg::*;
;
  logic clk = 1'h0, sys_rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
  logic thresh_sel, irq;
  logic [9:0] reg_addr = 10'h000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [3:0] fl = 4'h0;
  int err_total = 0, num_checks = 0, cyc = 0;
  psfr_status_readback DUT (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .vco_above_threshold(fl[3]), .irq, .thresh_sel,
    .ref_two_above_threshold(fl[2]), .ref_one_above_threshold(fl[1]),
    .pll_locked(fl[0]));
  // Clock, and a cycle ceiling well past the test length
  always #20 clk = ~clk;
  always @(posedge clk) if (++cyc == 1000) begin
    err_total++;
    wrap_up();
  end
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(logic [9:0] a, logic [7:0] d);
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'h1, a, d};
    @(posedge clk) reg_wr <= 1'h0;
  endtask
  // Data stand only in the cycle after the strobe
  task automatic rd(logic [9:0] a, logic [7:0] e);
    @(posedge clk) {reg_rd, reg_addr} <= {1'h1, a};
    @(posedge clk) reg_rd <= 1'h0;
    #1 chk("rdata", e, reg_rdata);
  endtask
  task automatic wrap_up();
    if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'h0;
    // Early read still sees the old flags
    for (int i = 0; i < 16; i++) begin
      @(posedge clk) fl <= 4'(i);
      rd(PLL_STATUS_OFS, 8'(i > 0 ? i - 1 : 0));
      wr(PLL_STATUS_OFS, 8'hFF);
      rd(PLL_STATUS_OFS, 8'(i));
    end
    wr(REF_CTRL_OFS, 8'h40);
    #1 chk("thresh_sel", 8'h01, 8'(thresh_sel));
    rd(10'h3FF, 8'h00);
    wr(IRQ_MASK_OFS, 8'h0F);
    #1 chk("irq", 8'h01, 8'(irq));
    wr(IRQ_STATUS_OFS, 8'hFF);
    #1 chk("irq", 8'h00, 8'(irq));
    // Lock drop sets a fall bit that the mask hides
    @(posedge clk) fl <= 4'hE;
    repeat (4) @(posedge clk);
    rd(IRQ_STATUS_OFS, 8'h10);
    chk("irq", 8'h00, 8'(irq));
    wrap_up();
  end
endmodule // psfr_status_readback_bench
